/* rtl/sfcp_regs.svh */
// constants of the serial flash command and protection block
`ifndef SFCP_REGS_SVH
`define SFCP_REGS_SVH

`define SFCP_OP_WRITE_ENABLE   8'h06
`define SFCP_OP_WRITE_DISABLE  8'h04
`define SFCP_OP_STATUS_READ    8'h05
`define SFCP_OP_STATUS_WRITE   8'h01
`define SFCP_OP_PAGE_PROGRAM   8'h02
`define SFCP_OP_SECTOR_ERASE   8'hD8
`define SFCP_OP_BULK_ERASE     8'hC7
`define SFCP_OP_DEEP_DOWN      8'hB9
`define SFCP_OP_RELEASE        8'hAB

`define SFCP_STB_BUSY          0
`define SFCP_STB_WEN           1
`define SFCP_STB_BLK_LO        2
`define SFCP_STB_BLK_HI        4
`define SFCP_STB_SPROT         7
`define SFCP_BLK_RESET         3'h0
`define SFCP_SPROT_RESET       1'h0

`define SFCP_ADDR_TOP          21'h1FFFFF
`define SFCP_PROT_SZ1          21'h000FFF
`define SFCP_PROT_SZ2          21'h001FFF
`define SFCP_PROT_SZ3          21'h003FFF
`define SFCP_PROT_SZ4          21'h007FFF
`define SFCP_PROT_SZ5          21'h00FFFF
`define SFCP_PROT_SZ6          21'h0FFFFF

`define SFCP_CORE_MHZ          100
`define SFCP_PROG_TIME_US      1500
`define SFCP_SECT_ERASE_MS     800
`define SFCP_BULK_ERASE_MS     18000
`define SFCP_STAT_WRITE_MS     10
`define SFCP_PWRUP_DELAY_MS    10
`define SFCP_PAGE_BYTES        9'h100
`define SFCP_HDR_BYTES         12'h004

`endif

/* rtl/sfcp_pkg.sv */
// types of the serial flash command and protection block
package sfcp_pkg;
  typedef enum logic [2:0] {SFCP_PWRUP, SFCP_IDLE, SFCP_STWR, SFCP_PROG, SFCP_ERASE} sfcp_state_t;

  typedef struct packed {
    logic       cs_s1, cs_s2, cs_s3, wp_s1, wp_s2, ack_s1, ack_s2, req, seen;
    logic [7:0] pub;
    sfcp_state_t st;
    logic       deep, wen, sprot, busy, active;
    logic [2:0] blk;
    logic [7:0] sr_new;
    logic [31:0] tmr;
    logic [12:0] pbase;
    logic [7:0] pidx;
    logic [8:0] pleft;
    logic       prog_v;
    logic [20:0] prog_a;
    logic [7:0] prog_clr;
    logic       er_go;
    logic [20:0] er_lo, er_hi;
  } sfcp_core_t;

  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] bits;
    logic [11:0] nbytes;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] srd;
    logic [7:0] stat;
    logic       seq, busy_s1, busy_s2;
  } sfcp_link_t;

  typedef struct packed {
    logic fresh, req_s1, req_s2, ack;
  } sfcp_hs_t;

  typedef struct packed {
    logic       oe, so;
    logic [7:0] obyte;
  } sfcp_out_t;
endpackage

/* rtl/sfcp_top.sv */
// command decode, write protection and cycle control of the serial flash
`timescale 1ns/1ps
`default_nettype none
`include "sfcp_regs.svh"
module sfcp_top
  import sfcp_pkg::*;
#(
  parameter bit          TOP_BOOT     = 1'b0,
  parameter int unsigned PROG_CYCLES  = `SFCP_PROG_TIME_US * `SFCP_CORE_MHZ,
  parameter int unsigned SECT_CYCLES  = `SFCP_SECT_ERASE_MS * 1000 * `SFCP_CORE_MHZ,
  parameter int unsigned BULK_CYCLES  = `SFCP_BULK_ERASE_MS * 1000 * `SFCP_CORE_MHZ,
  parameter int unsigned STWR_CYCLES  = `SFCP_STAT_WRITE_MS * 1000 * `SFCP_CORE_MHZ,
  parameter int unsigned PWRUP_CYCLES = `SFCP_PWRUP_DELAY_MS * 1000 * `SFCP_CORE_MHZ
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        serial_in,
  input  wire logic        wp_n,
  output var  logic        serial_out,
  output var  logic        serial_out_oe,
  output var  logic        power_active,
  output var  logic        power_deep,
  output var  logic        mem_prog_valid,
  output var  logic [20:0] mem_prog_addr,
  output var  logic [7:0]  mem_prog_clr,
  output var  logic        mem_erase_start,
  output var  logic [20:0] mem_erase_lo,
  output var  logic [20:0] mem_erase_hi
);

  sfcp_core_t c_r, c_nxt;
  sfcp_link_t l_r, l_nxt;
  sfcp_hs_t   h_r, h_nxt;
  sfcp_out_t  o_r, o_nxt;
  logic [7:0] pbuf [256];

  // ---------------- link domain, runs only while the host clocks ----------------
  logic [2:0]  lk_bits;
  logic [11:0] lk_nb;
  logic        lk_wr;
  logic [7:0]  lk_widx;

  always_comb begin
    l_nxt = l_r;
    h_nxt = h_r;
    lk_bits = h_r.fresh ? 3'h0 : l_r.bits;
    lk_nb   = h_r.fresh ? 12'h000 : l_r.nbytes;
    h_nxt.fresh  = 1'b0;
    h_nxt.req_s1 = c_r.req;
    h_nxt.req_s2 = h_r.req_s1;
    l_nxt.busy_s1 = c_r.busy;
    l_nxt.busy_s2 = l_r.busy_s1;
    // status copy only while the core holds its word still
    if (h_r.req_s2 && !h_r.ack) begin
      l_nxt.stat = c_r.pub;
      h_nxt.ack  = 1'b1;
    end else if (!h_r.req_s2) begin
      h_nxt.ack = 1'b0;
    end
    // frame marker follows the core's last seen value: needs no reset, and a
    // mode 3 park edge while deselected cannot cancel the next frame
    if (h_r.fresh) begin
      l_nxt.seq = ~c_r.seen;
    end
    l_nxt.sh   = {l_r.sh[6:0], serial_in};
    l_nxt.bits = lk_bits + 3'h1;
    l_nxt.nbytes = lk_nb;
    if (lk_bits == 3'h7) begin
      if (lk_nb == 12'h000) begin
        l_nxt.op = l_nxt.sh;
      end
      if (lk_nb == 12'h001) begin
        l_nxt.srd = l_nxt.sh;
      end
      if (lk_nb != 12'h000 && lk_nb < `SFCP_HDR_BYTES) begin
        l_nxt.addr = {l_r.addr[15:0], l_nxt.sh};
      end
      if (lk_nb != 12'hFFF) begin
        l_nxt.nbytes = lk_nb + 12'h001;
      end
    end
    // data goes to the page buffer only while no cycle reads it
    lk_wr   = lk_bits == 3'h7 && lk_nb >= `SFCP_HDR_BYTES && !l_r.busy_s2 &&
              l_r.op == `SFCP_OP_PAGE_PROGRAM;
    lk_widx = l_r.addr[7:0] + 8'(lk_nb - `SFCP_HDR_BYTES);
  end

  // cs_n high presets the frame start and handshake; the clock is parked then
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      h_r <= '{fresh: 1'b1, req_s1: 1'b0, req_s2: 1'b0, ack: 1'b0};
    end else begin
      h_r <= h_nxt;
    end
  end

  always_ff @(posedge sclk) begin
    l_r <= l_nxt;
    if (lk_wr) begin
      pbuf[lk_widx] <= l_nxt.sh;
    end
  end

  // status read: launched on falling edges; a mode 3 frame opens with one
  always_comb begin
    o_nxt = o_r;
    o_nxt.oe = !h_r.fresh && l_r.op == `SFCP_OP_STATUS_READ && l_r.nbytes != 12'h000;
    if (l_r.bits == 3'h0) begin
      o_nxt.so    = l_r.stat[7];
      o_nxt.obyte = {l_r.stat[6:0], 1'b0};
    end else begin
      o_nxt.so    = o_r.obyte[7];
      o_nxt.obyte = {o_r.obyte[6:0], 1'b0};
    end
    if (!o_nxt.oe) begin
      o_nxt.so = 1'b0;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      o_r <= '0;
    end else begin
      o_r <= o_nxt;
    end
  end

  // ---------------- core domain ----------------
  logic        fe, hardware_protected_mode, blk_on, aligned;
  logic [20:0] a21, am, psz, smask, lo_m, hi_m;
  logic [11:0] ndata;

  always_comb begin
    a21 = l_r.addr[20:0];
    am  = TOP_BOOT ? ~a21 : a21;
    case (c_r.blk)
      3'h1:    psz = `SFCP_PROT_SZ1;
      3'h2:    psz = `SFCP_PROT_SZ2;
      3'h3:    psz = `SFCP_PROT_SZ3;
      3'h4:    psz = `SFCP_PROT_SZ4;
      3'h5:    psz = `SFCP_PROT_SZ5;
      3'h6:    psz = `SFCP_PROT_SZ6;
      default: psz = `SFCP_ADDR_TOP;
    endcase
    if (am <= `SFCP_PROT_SZ2) begin
      smask = `SFCP_PROT_SZ1;
    end else if (am <= `SFCP_PROT_SZ3) begin
      smask = `SFCP_PROT_SZ2;
    end else if (am <= `SFCP_PROT_SZ4) begin
      smask = `SFCP_PROT_SZ3;
    end else if (am <= `SFCP_PROT_SZ5) begin
      smask = `SFCP_PROT_SZ4;
    end else begin
      smask = `SFCP_PROT_SZ5;
    end
    lo_m    = am & ~smask;
    hi_m    = am | smask;
    blk_on  = c_r.blk != 3'h0;
    hardware_protected_mode     = c_r.sprot && !c_r.wp_s2;
    fe      = c_r.cs_s2 && !c_r.cs_s3 && l_r.seq != c_r.seen;
    aligned = l_r.bits == 3'h0;
    ndata   = l_r.nbytes - `SFCP_HDR_BYTES;
  end

  always_comb begin
    c_nxt = c_r;
    c_nxt.cs_s1  = cs_n;
    c_nxt.cs_s2  = c_r.cs_s1;
    c_nxt.cs_s3  = c_r.cs_s2;
    c_nxt.wp_s1  = wp_n;
    c_nxt.wp_s2  = c_r.wp_s1;
    c_nxt.ack_s1 = h_r.ack;
    c_nxt.ack_s2 = c_r.ack_s1;
    c_nxt.prog_v = 1'b0;
    c_nxt.er_go  = 1'b0;
    // four-phase publish of the status word toward the link; while deselected
    // the link reads nothing, so the held word is refreshed and never stale
    if (!c_r.ack_s2 && (!c_r.req || c_r.cs_s2)) begin
      c_nxt.pub = 8'h00;
      c_nxt.pub[`SFCP_STB_BUSY] = c_r.busy;
      c_nxt.pub[`SFCP_STB_WEN]  = c_r.wen;
      c_nxt.pub[`SFCP_STB_BLK_HI:`SFCP_STB_BLK_LO] = c_r.blk;
      c_nxt.pub[`SFCP_STB_SPROT] = c_r.sprot;
      c_nxt.req = 1'b1;
    end else if (c_r.req && c_r.ack_s2) begin
      c_nxt.req = 1'b0;
    end
    if (c_r.cs_s2 && !c_r.cs_s3) begin
      c_nxt.seen = l_r.seq;
    end
    c_nxt.tmr = c_r.tmr - 32'h1;
    case (c_r.st)
      SFCP_PWRUP: begin
        if (c_r.tmr == 32'h0) begin
          c_nxt.st = SFCP_IDLE;
        end
      end
      SFCP_IDLE: begin
        c_nxt.tmr = c_r.tmr;
        if (fe && l_r.nbytes != 12'h000) begin
          if (c_r.deep) begin
            if (l_r.op == `SFCP_OP_RELEASE) begin
              c_nxt.deep = 1'b0;
            end
          end else if (aligned) begin
            case (l_r.op)
              `SFCP_OP_WRITE_ENABLE: c_nxt.wen = 1'b1;
              `SFCP_OP_WRITE_DISABLE: c_nxt.wen = 1'b0;
              `SFCP_OP_DEEP_DOWN: c_nxt.deep = 1'b1;
              `SFCP_OP_STATUS_WRITE: begin
                if (c_r.wen && !hardware_protected_mode && l_r.nbytes >= 12'h002) begin
                  c_nxt.sr_new = l_r.srd;
                  c_nxt.tmr = 32'(STWR_CYCLES - 1);
                  c_nxt.st = SFCP_STWR;
                end
              end
              `SFCP_OP_PAGE_PROGRAM: begin
                if (c_r.wen && l_r.nbytes > `SFCP_HDR_BYTES &&
                    !(blk_on && am <= psz)) begin
                  c_nxt.pbase = a21[20:8];
                  c_nxt.pidx  = a21[7:0];
                  c_nxt.pleft = (ndata > 12'h100) ? `SFCP_PAGE_BYTES : ndata[8:0];
                  c_nxt.tmr = 32'(PROG_CYCLES - 1);
                  c_nxt.st = SFCP_PROG;
                end
              end
              `SFCP_OP_SECTOR_ERASE: begin
                if (c_r.wen && l_r.nbytes == `SFCP_HDR_BYTES &&
                    !(blk_on && lo_m <= psz)) begin
                  c_nxt.er_lo = TOP_BOOT ? ~hi_m : lo_m;
                  c_nxt.er_hi = TOP_BOOT ? ~lo_m : hi_m;
                  c_nxt.er_go = 1'b1;
                  c_nxt.tmr = 32'(SECT_CYCLES - 1);
                  c_nxt.st = SFCP_ERASE;
                end
              end
              `SFCP_OP_BULK_ERASE: begin
                if (c_r.wen && l_r.nbytes == 12'h001 && !blk_on) begin
                  c_nxt.er_lo = 21'h000000;
                  c_nxt.er_hi = `SFCP_ADDR_TOP;
                  c_nxt.er_go = 1'b1;
                  c_nxt.tmr = 32'(BULK_CYCLES - 1);
                  c_nxt.st = SFCP_ERASE;
                end
              end
              default: c_nxt.wen = c_r.wen;
            endcase
          end
        end
      end
      SFCP_STWR: begin
        if (c_r.tmr == 32'h0) begin
          c_nxt.sprot = c_r.sr_new[`SFCP_STB_SPROT];
          c_nxt.blk   = c_r.sr_new[`SFCP_STB_BLK_HI:`SFCP_STB_BLK_LO];
          c_nxt.wen   = 1'b0;
          c_nxt.st    = SFCP_IDLE;
        end
      end
      SFCP_PROG: begin
        if (c_r.pleft != 9'h000) begin
          c_nxt.prog_v   = 1'b1;
          c_nxt.prog_a   = {c_r.pbase, c_r.pidx};
          c_nxt.prog_clr = ~pbuf[c_r.pidx];
          c_nxt.pidx     = c_r.pidx + 8'h01;
          c_nxt.pleft    = c_r.pleft - 9'h001;
        end else if (c_r.tmr[31] || c_r.tmr == 32'h0) begin
          c_nxt.wen = 1'b0;
          c_nxt.st  = SFCP_IDLE;
        end
      end
      SFCP_ERASE: begin
        if (c_r.tmr == 32'h0) begin
          c_nxt.wen = 1'b0;
          c_nxt.st  = SFCP_IDLE;
        end
      end
      default: c_nxt.st = SFCP_IDLE;
    endcase
    // other frames during a cycle fall on the floor
    c_nxt.busy   = c_nxt.st == SFCP_STWR || c_nxt.st == SFCP_PROG ||
                   c_nxt.st == SFCP_ERASE;
    c_nxt.active = !c_r.cs_s2 || c_nxt.busy;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      c_r       <= '0;
      c_r.cs_s1 <= 1'b1;
      c_r.cs_s2 <= 1'b1;
      c_r.cs_s3 <= 1'b1;
      c_r.wp_s1 <= 1'b1;
      c_r.wp_s2 <= 1'b1;
      c_r.st    <= SFCP_PWRUP;
      c_r.tmr   <= 32'(PWRUP_CYCLES - 1);
      c_r.blk   <= `SFCP_BLK_RESET;
      c_r.sprot <= `SFCP_SPROT_RESET;
      c_r.active <= 1'b0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign serial_out      = o_r.so;
  assign serial_out_oe   = o_r.oe;
  assign power_active    = c_r.active;
  assign power_deep      = c_r.deep;
  assign mem_prog_valid  = c_r.prog_v;
  assign mem_prog_addr   = c_r.prog_a;
  assign mem_prog_clr    = c_r.prog_clr;
  assign mem_erase_start = c_r.er_go;
  assign mem_erase_lo    = c_r.er_lo;
  assign mem_erase_hi    = c_r.er_hi;

  // ---------------- checks ----------------
  a_erase_needs_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(c_r.er_go) |-> $past(c_r.wen) && !$past(c_r.deep))
    else $error("erase started without write enable latch");

  a_prog_needs_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
    (c_r.st == SFCP_PROG && $past(c_r.st) == SFCP_IDLE) |-> $past(c_r.wen))
    else $error("program started without write enable latch");

  a_latch_done_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    ($past(c_r.busy) && c_r.st == SFCP_IDLE) |-> !c_r.wen)
    else $error("latch still set after cycle completion");

  a_prog_in_page: assert property (@(posedge core_clk) disable iff (!reset_n)
    (mem_prog_valid && $past(mem_prog_valid)) |->
      mem_prog_addr[20:8] == $past(mem_prog_addr[20:8]) &&
      mem_prog_addr[7:0] == $past(mem_prog_addr[7:0]) + 8'h01)
    else $error("program stream left its page");

  a_erase_unprotected: assert property (@(posedge core_clk) disable iff (!reset_n)
    mem_erase_start |-> $past(c_r.blk) == 3'h0 || $past(psz) < (TOP_BOOT ?
      (`SFCP_ADDR_TOP - mem_erase_hi) : mem_erase_lo))
    else $error("erase reached a protected region");

  a_hpm_frozen: assert property (@(posedge core_clk) disable iff (!reset_n)
    (c_r.sprot && !c_r.wp_s2 && c_r.st == SFCP_IDLE) |=>
      $stable(c_r.blk) && c_r.sprot && c_r.st != SFCP_STWR)
    else $error("status protect bits changed in hardware mode");

  a_deep_silent: assert property (@(posedge core_clk) disable iff (!reset_n)
    c_r.deep |=> !c_r.busy && !mem_prog_valid && !mem_erase_start)
    else $error("cycle started in deep power-down");

  a_pwrup_block: assert property (@(posedge core_clk) disable iff (!reset_n)
    c_r.st == SFCP_PWRUP |-> ##1 !c_r.busy [*2])
    else $error("modifying cycle during power-up delay");

  a_standby_entry: assert property (@(posedge core_clk) disable iff (!reset_n)
    c_r.cs_s2 |=> power_active == c_r.busy)
    else $error("still active while deselected and idle");

  a_busy_erase: assert property (@(posedge core_clk) disable iff (!reset_n)
    mem_erase_start |-> c_r.busy ##1 c_r.busy)
    else $error("busy flag low during erase");

  // refusals leave latch, cycle state and power state untouched
  a_misaligned_refused: assert property (@(posedge core_clk) disable iff (!reset_n)
    (fe && !aligned && !c_r.deep && c_r.st == SFCP_IDLE && l_r.nbytes != 12'h000) |=>
      $stable(c_r.wen) && !c_r.busy && !c_r.deep)
    else $error("misaligned frame was executed");

  a_deep_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
    (fe && c_r.deep && l_r.op != `SFCP_OP_RELEASE) |=> c_r.deep && $stable(c_r.wen))
    else $error("deep power-down left without release");

  a_stwr_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
    (c_r.st == SFCP_STWR && $past(c_r.st) == SFCP_IDLE) |-> $past(c_r.wen) && !$past(hardware_protected_mode))
    else $error("status write started without latch or under hardware protection");

  c_prog_run: cover property (@(posedge core_clk) disable iff (!reset_n)
    mem_prog_valid ##1 mem_prog_valid);
  c_erase_run: cover property (@(posedge core_clk) disable iff (!reset_n) mem_erase_start);
  c_deep_exit: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(c_r.deep));
  c_stat_write: cover property (@(posedge core_clk) disable iff (!reset_n)
    c_r.st == SFCP_STWR ##1 c_r.st == SFCP_IDLE);
  c_misaligned: cover property (@(posedge core_clk) disable iff (!reset_n)
    fe && !aligned);

endmodule
`default_nettype wire

/* dv/sfcp_host.sv */
// host serial master model that frames commands on the flash link
`timescale 1ns/1ps
`default_nettype none
module sfcp_host (
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic serial_in
);
  localparam realtime HALF = 62.5;
  bit mode3;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
    mode3 = 1'b0;
  end
  // park level only changes while deselected
  task automatic park(input bit m);
    mode3 = m;
    sclk = m;
    #HALF;
  endtask
  task automatic frame(input logic [7:0] b [$], input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      serial_in = b[i / 8][7 - i % 8];
      #HALF;
      sclk = 1'b1;
      rd = {rd[6:0], serial_out_oe ? serial_out : 1'b0};
      #HALF;
    end
    sclk = mode3;
    #HALF;
    cs_n = 1'b1;
    // released line must not keep its old level
    serial_in = ~serial_in;
    #100;
  endtask
endmodule
`default_nettype wire

/* dv/test_serial_flash_command_protection.sv */
// self-checking bench of the flash command and protection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module test_serial_flash_command_protection;
  logic        core_clk, reset_n, wp_n, sclk, cs_n, serial_in, serial_out, serial_out_oe;
  logic        power_active, power_deep, mem_prog_valid, mem_erase_start;
  logic [20:0] mem_prog_addr, mem_erase_lo, mem_erase_hi, a;
  logic [7:0]  mem_prog_clr, s;
  logic [28:0] prog_q [$];
  logic [41:0] er_q [$];
  logic        m_wen, m_sprot;
  logic [2:0]  m_blk;
  int          miscompares, n_compared, seed;
  sfcp_top #(.PROG_CYCLES(400), .SECT_CYCLES(200), .BULK_CYCLES(300),
    .STWR_CYCLES(50), .PWRUP_CYCLES(300)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .wp_n(wp_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .power_active(power_active), .power_deep(power_deep),
    .mem_prog_valid(mem_prog_valid), .mem_prog_addr(mem_prog_addr),
    .mem_prog_clr(mem_prog_clr), .mem_erase_start(mem_erase_start),
    .mem_erase_lo(mem_erase_lo), .mem_erase_hi(mem_erase_hi));
  sfcp_host host (.serial_out(serial_out), .serial_out_oe(serial_out_oe), .sclk(sclk),
    .cs_n(cs_n), .serial_in(serial_in));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (mem_prog_valid === 1'b1)
      prog_q.push_back({mem_prog_addr, mem_prog_clr});
    if (mem_erase_start === 1'b1)
      er_q.push_back({mem_erase_lo, mem_erase_hi});
  end
  function automatic logic [7:0] exp_stat();
    return {m_sprot, 2'b00, m_blk, m_wen, 1'b0};
  endfunction
  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b [$]);
    logic [7:0] d;
    host.frame(b, b.size() * 8, d);
  endtask
  task automatic chk_stat(input string nm);
    logic [7:0] r;
    host.frame('{8'h05, 8'h00}, 16, r);
    `CHK(nm, exp_stat(), r)
  endtask
  // polling instead of waiting the worst case
  task automatic wait_idle();
    logic [7:0] r;
    for (int i = 0; i < 60; i++) begin
      host.frame('{8'h05, 8'h00}, 16, r);
      if (r[0] === 1'b0)
        return;
    end
    miscompares++;
    close_out();
  endtask
  task automatic prog(input logic [20:0] pa, input int n, input bit ok, input bit we);
    logic [7:0]  b [$];
    logic [28:0] e [$];
    logic [7:0]  d;
    b = '{8'h02, {3'h0, pa[20:16]}, pa[15:8], pa[7:0]};
    prog_q.delete();
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      b.push_back(d);
      if (ok)
        e.push_back({pa + 21'(i), ~d});
    end
    if (we) begin
      cmd('{8'h06});
      m_wen = 1'b1;
    end
    cmd(b);
    if (ok) begin
      `CHK("active", 1'b1, power_active)
      wait_idle();
      m_wen = 1'b0;
    end
    chk_stat("prog latch");
    `CHK("prog count", e.size(), prog_q.size())
    foreach (e[i]) `CHK("prog byte", e[i], prog_q[i])
    `CHK("standby", 1'b0, power_active)
  endtask
  task automatic erase(input logic [7:0] op, input logic [20:0] ea, input bit ok);
    er_q.delete();
    cmd('{8'h06});
    m_wen = 1'b1;
    if (op == 8'hC7)
      cmd('{op});
    else
      cmd('{op, {3'h0, ea[20:16]}, ea[15:8], ea[7:0]});
    if (ok) begin
      wait_idle();
      m_wen = 1'b0;
    end
    chk_stat("erase latch");
    `CHK("erase count", ok ? 1 : 0, er_q.size())
    if (op == 8'hC7 && ok)
      `CHK("bulk span", {21'h0, 21'h1FFFFF}, er_q[0])
    else if (ok)
      `CHK("sector span", {ea & 21'h1F0000, ea | 21'h00FFFF}, er_q[0])
  endtask
  task automatic status_write_cmd(input logic [7:0] v, input bit ok);
    cmd('{8'h06});
    m_wen = 1'b1;
    cmd('{8'h01, v});
    if (ok) begin
      wait_idle();
      m_wen = 1'b0;
      m_blk = v[4:2];
      m_sprot = v[7];
    end
    chk_stat("status write");
  endtask
  initial begin
    #900us;
    miscompares++;
    close_out();
  end
  initial begin
    reset_n = 1'b0;
    wp_n = 1'b1;
    {m_wen, m_sprot, m_blk} = 5'h00;
    seed = $urandom(11);
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    cmd('{8'h06});
    chk_stat("power-up");
    #3000;
    for (int m = 0; m < 2; m++) begin
      host.park(m[0]);
      cmd('{8'h06});
      m_wen = 1'b1;
      chk_stat("latch set");
      cmd('{8'h04});
      m_wen = 1'b0;
      chk_stat("latch clear");
      host.frame('{8'h06, 8'h00}, 9, s);
      chk_stat("misaligned");
      a = 21'h010000 | (21'($urandom) & 21'h1FFF7C);
      prog(a, 1, 1'b0, 1'b0);
      prog(a, 1 + $urandom % 4, 1'b1, 1'b1);
      status_write_cmd(8'h04, 1'b1);
      prog(21'h000010, 2, 1'b0, 1'b1);
      erase(8'hD8, a, 1'b1);
      erase(8'hD8, 21'h000800, 1'b0);
      status_write_cmd(8'h84, 1'b1);
      @(negedge core_clk) wp_n = 1'b0;
      status_write_cmd(8'h00, 1'b0);
      @(negedge core_clk) wp_n = 1'b1;
      status_write_cmd(8'h00, 1'b1);
      erase(8'hC7, 21'h0, 1'b1);
      cmd('{8'hB9});
      `CHK("deep", 1'b1, power_deep)
      cmd('{8'h06});
      cmd('{8'hAB});
      `CHK("release", 1'b0, power_deep)
      chk_stat("deep ignore");
    end
    close_out();
  end
endmodule
`default_nettype wire
